// [flash_id_device.sv]
`timescale 1ns/1ps
`default_nettype none
`include "flash_id_consts.svh"

// Overview of operation
// RL1 - 9F single-line: maker byte, two part bytes
// RL2 - AB: two don't-care bytes, then signature
// RL3 - 90: address byte picks maker or part first
// RL4 - AF only in quad mode, quad identity
// RL5 - 5A: three address bytes, eight dummy clocks
// RL6 - B1 enters secure area, C1 leaves it
// RL7 - 2B shifts out the security register
// RL8 - 2F sets lock-down bit, cleared only by system reset
// RL9 - Host sends 66 before 99
// RL10 - Any other command drops the armed reset
// RL11 - Multi-line units: MSB on higher lane
// RL12 - Host sends only defined opcodes
// RL13 - Unknown opcode ignored until deselect
module flash_id_device (
  // Link to the host controller
  flash_link_if.dev LINK,
  // System clock and reset
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  // State seen by the system
  output logic OTP_ACTIVE,
  output logic LOCKED,
  output logic QUAD_ACTIVE,
  output logic SOFT_RESET
);
  import flash_id_pkg::*;

  localparam logic [7:0] DISC_TABLE [16] = '{
    8'h53, 8'h46, 8'h44, 8'h50, 8'h06, 8'h01, 8'h01, 8'hff,
    8'h00, 8'h06, 8'h01, 8'h10, 8'h30, 8'h00, 8'h00, 8'hff
  };

  dev_state_t state;
  out_kind_t kind;
  logic rst_meta;
  logic link_rst;
  logic [4:0] rem;
  logic [2:0] ocnt;
  logic [7:0] idx;
  logic [23:0] sh;
  logic [7:0] addr;
  logic quad;
  logic otp;
  logic lock;
  logic armed;
  logic rst_tgl;
  logic [23:0] next_sh;
  logic [7:0] op;
  logic [2:0] byte_last;
  logic op_done;
  logic [7:0] obyte;
  logic [3:0] dout;
  logic [3:0] doe_n;
  logic [3:0] lvl_meta;
  logic [3:0] lvl;
  logic tgl_prev;

  function automatic logic [4:0] addr_clks(input logic [1:0] nbytes, input logic q);
    return q ? {2'b00, nbytes, 1'b0} : {nbytes, 3'b000};
  endfunction : addr_clks

  // Reset is taken at once and let go on the link clock, which stands still during reset.
  always_ff @(posedge LINK.sclk or posedge SYS_RST) begin
    if (SYS_RST) begin
      rst_meta <= 1'b1;
      link_rst <= 1'b1;
    end else begin
      rst_meta <= 1'b0;
      link_rst <= rst_meta;
    end
  end

  always_comb begin
    // Lane 1 sits above lane 0, so it carries the more significant bit. see RL11
    next_sh = quad ? {sh[19:0], LINK.h_io} : {sh[22:0], LINK.h_io[0]};
    op = next_sh[7:0];
    byte_last = quad ? 3'd1 : 3'd7;
    op_done = (state == S_OP) && (ocnt == byte_last);
  end

  // Frame logic is cleared by deselect, since the clock stops between frames.
  always_ff @(posedge LINK.sclk or posedge LINK.cs_n) begin
    if (LINK.cs_n) begin
      state <= S_OP;
      kind <= K_SIG;
      ocnt <= 3'd0;
      rem <= 5'd0;
      idx <= 8'h00;
      sh <= 24'h000000;
      addr <= 8'h00;
    end else begin
      sh <= next_sh;
      case (state)
        S_OP: begin
          ocnt <= (ocnt == byte_last) ? 3'd0 : 3'(ocnt + 3'd1);
          if (op_done) begin
            state <= S_IGNORE; // see RL13
            case (op)
              `OP_JEDEC_ID: begin
                if (!quad) begin
                  state <= S_OUT; // see RL1
                  kind <= K_JEDEC;
                end
              end
              `OP_QUAD_ID: begin
                if (quad) begin
                  state <= S_OUT; // see RL4
                  kind <= K_JEDEC;
                end
              end
              `OP_LEGACY_SIG: begin
                state <= S_ADDR; // see RL2
                kind <= K_SIG;
                rem <= 5'(addr_clks(2'd2, quad) - 5'd1);
              end
              `OP_MAKER_PAIR: begin
                if (!quad) begin
                  state <= S_ADDR; // see RL3
                  kind <= K_PAIR;
                  rem <= 5'(addr_clks(2'd3, quad) - 5'd1);
                end
              end
              `OP_DISC_TABLE: begin
                state <= S_ADDR; // see RL5
                kind <= K_TABLE;
                rem <= 5'(addr_clks(2'd3, quad) - 5'd1);
              end
              `OP_SEC_READ: begin
                state <= S_OUT; // see RL7
                kind <= K_SEC;
              end
              default: begin
              end
            endcase
          end
        end
        S_ADDR: begin
          if (rem == 5'd0) begin
            addr <= next_sh[7:0];
            if (kind == K_TABLE) begin
              state <= S_DUMMY; // see RL5
              rem <= 5'(`DUMMY_CLKS - 5'd1);
            end else begin
              state <= S_OUT;
            end
          end else begin
            rem <= 5'(rem - 5'd1);
          end
        end
        S_DUMMY: begin
          if (rem == 5'd0) begin
            state <= S_OUT;
          end else begin
            rem <= 5'(rem - 5'd1);
          end
        end
        S_OUT: begin
          ocnt <= (ocnt == byte_last) ? 3'd0 : 3'(ocnt + 3'd1);
          if (ocnt == byte_last) begin
            idx <= (kind == K_JEDEC && idx == 8'd2) ? 8'h00 : 8'(idx + 8'd1);
          end
        end
        S_IGNORE: begin
        end
        default: begin
          state <= S_IGNORE;
        end
      endcase
    end
  end

  // Persistent state changes as soon as the opcode is complete.
  always_ff @(posedge LINK.sclk or posedge link_rst) begin
    if (link_rst) begin
      quad <= 1'b0;
      otp <= 1'b0;
      lock <= 1'b0;
      armed <= 1'b0;
    end else if (op_done) begin
      armed <= (op == `OP_RESET_ARM); // see RL10
      case (op)
        `OP_ENTER_OTP: begin
          otp <= 1'b1; // see RL6
        end
        `OP_EXIT_OTP: begin
          otp <= 1'b0; // see RL6
        end
        `OP_SEC_LOCK: begin
          lock <= 1'b1; // see RL8
        end
        `OP_QUAD_ENTER: begin
          if (!quad) begin
            quad <= 1'b1;
          end
        end
        `OP_QUAD_EXIT: begin
          if (quad) begin
            quad <= 1'b0;
          end
        end
        `OP_RESET_GO: begin
          // Lock-down survives a soft reset. see RL8
          if (armed) begin
            otp <= 1'b0; // see RL9
            quad <= 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge LINK.sclk or posedge link_rst) begin
    if (link_rst) begin
      rst_tgl <= 1'b0;
    end else if (op_done && op == `OP_RESET_GO && armed) begin
      rst_tgl <= ~rst_tgl; // see RL10
    end
  end

  always_comb begin
    case (kind)
      K_JEDEC: begin
        obyte = (idx == 8'd0) ? `MAKER_ID : ((idx == 8'd1) ? `PART_HI : `PART_LO); // see RL1
      end
      K_SIG: begin
        obyte = `LEGACY_SIG; // see RL2
      end
      K_PAIR: begin
        // The pair alternates for as long as the host keeps clocking.
        obyte = ((addr == `PAIR_PART_FIRST) ^ idx[0]) ? `PART_LO : `MAKER_ID; // see RL3
      end
      K_TABLE: begin
        obyte = DISC_TABLE[4'(addr[3:0] + idx[3:0])];
      end
      K_SEC: begin
        obyte = {6'h00, lock, otp}; // see RL7
      end
      default: begin
        obyte = 8'h00;
      end
    endcase
  end

  // Data changes on the falling edge so the host samples it on the rising one.
  always_ff @(negedge LINK.sclk or posedge LINK.cs_n) begin
    if (LINK.cs_n) begin
      dout <= 4'h0;
      doe_n <= 4'hf;
    end else if (state == S_OUT) begin
      if (quad) begin
        dout <= ocnt[0] ? obyte[3:0] : obyte[7:4]; // see RL4
        doe_n <= 4'h0;
      end else begin
        dout <= {2'b00, obyte[3'd7 - ocnt], 1'b0};
        doe_n <= 4'hd;
      end
    end else begin
      doe_n <= 4'hf;
    end
  end

  assign LINK.d_io = dout;
  assign LINK.d_oe_n = doe_n;

  // Levels cross by two flops; the reset event crosses as a toggle.
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      lvl_meta <= 4'h0;
      lvl <= 4'h0;
      tgl_prev <= 1'b0;
      OTP_ACTIVE <= 1'b0;
      LOCKED <= 1'b0;
      QUAD_ACTIVE <= 1'b0;
      SOFT_RESET <= 1'b0;
    end else begin
      lvl_meta <= {rst_tgl, quad, lock, otp};
      lvl <= lvl_meta;
      tgl_prev <= lvl[3];
      OTP_ACTIVE <= lvl[0];
      LOCKED <= lvl[1];
      QUAD_ACTIVE <= lvl[2];
      SOFT_RESET <= lvl[3] ^ tgl_prev;
    end
  end
endmodule : flash_id_device

`default_nettype wire

// [flash_id_consts.svh]
`ifndef FLASH_ID_CONSTS_SVH
`define FLASH_ID_CONSTS_SVH

// Opcodes handled by both ends.
`define OP_JEDEC_ID 8'h9f
`define OP_LEGACY_SIG 8'hab
`define OP_MAKER_PAIR 8'h90
`define OP_QUAD_ID 8'haf
`define OP_DISC_TABLE 8'h5a
`define OP_ENTER_OTP 8'hb1
`define OP_EXIT_OTP 8'hc1
`define OP_SEC_READ 8'h2b
`define OP_SEC_LOCK 8'h2f
`define OP_RESET_ARM 8'h66
`define OP_RESET_GO 8'h99
`define OP_NOP 8'h00
`define OP_QUAD_ENTER 8'h35
`define OP_QUAD_EXIT 8'hf5

// Identity values; all of them are arbitrary.
`define MAKER_ID 8'h3c
`define PART_HI 8'h20
`define PART_LO 8'h18
`define LEGACY_SIG 8'h17

// Address selector values for the maker and part pair read.
`define PAIR_MAKER_FIRST 8'h00
`define PAIR_PART_FIRST 8'h01

// Timing counts in link clocks and reference clocks.
`define DUMMY_CLKS 5'd8
`define SCLK_HALF 3'd4
`define WAKE_PULSES 12'd4

`endif

// [flash_id_pkg.sv]
`default_nettype none

package flash_id_pkg;

  typedef enum {S_OP, S_ADDR, S_DUMMY, S_OUT, S_IGNORE} dev_state_t;

  typedef enum {K_JEDEC, K_SIG, K_PAIR, K_TABLE, K_SEC} out_kind_t;

  typedef enum {H_WAKE, H_IDLE, H_RUN, H_GAP} host_state_t;

endpackage : flash_id_pkg

`default_nettype wire

// [flash_link_if.sv]
`timescale 1ns/1ps
`default_nettype none

interface flash_link_if;
  logic cs_n;
  logic sclk;
  logic [3:0] h_io;
  logic [3:0] h_oe_n;
  logic [3:0] d_io;
  logic [3:0] d_oe_n;

  modport host (
    output cs_n,
    output sclk,
    output h_io,
    output h_oe_n,
    input d_io,
    input d_oe_n
  );

  modport dev (
    input cs_n,
    input sclk,
    input h_io,
    input h_oe_n,
    output d_io,
    output d_oe_n
  );
endinterface : flash_link_if

`default_nettype wire

// [flash_id_host.sv]
`timescale 1ns/1ps
`default_nettype none
`include "flash_id_consts.svh"

module flash_id_host (
  // System clock and reset
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  // Command request
  input wire logic CMD_VALID,
  input wire logic [7:0] CMD_OP,
  input wire logic [23:0] CMD_ADDR,
  input wire logic [7:0] CMD_RD_BYTES,
  output logic CMD_READY,
  output logic CMD_ERROR,
  // Read data and link mode
  output logic RD_VALID,
  output logic [7:0] RD_DATA,
  output logic HOST_QUAD,
  // Link to the flash
  flash_link_if.host LINK
);
  import flash_id_pkg::*;

  host_state_t state;
  logic [2:0] tick;
  logic sclk_r;
  logic cs_r;
  logic [39:0] tx;
  logic [3:0] hout;
  logic [3:0] hoe_n;
  logic [11:0] clk_cnt;
  logic [11:0] cmd_clks;
  logic [11:0] total_clks;
  logic [7:0] rx;
  logic [2:0] rxc;
  logic armed;
  logic mode_after;
  logic [3:0] din_meta;
  logic [3:0] din;
  logic legal;
  logic reads;
  logic [1:0] nb;
  logic [11:0] new_cmd;
  logic [39:0] new_tx;
  logic [39:0] next_tx;
  logic [7:0] next_rx;

  always_comb begin
    legal = 1'b1;
    reads = 1'b0;
    nb = 2'd0;
    // Only defined opcodes go out, the mode-bound ones only in their own mode. see RL12
    case (CMD_OP)
      `OP_JEDEC_ID: begin
        legal = !HOST_QUAD;
        reads = 1'b1;
      end
      `OP_QUAD_ID: begin
        legal = HOST_QUAD;
        reads = 1'b1;
      end
      `OP_LEGACY_SIG: begin
        reads = 1'b1;
        nb = 2'd2;
      end
      `OP_MAKER_PAIR: begin
        legal = !HOST_QUAD;
        reads = 1'b1;
        nb = 2'd3;
      end
      `OP_DISC_TABLE: begin
        reads = 1'b1;
        nb = 2'd3;
      end
      `OP_SEC_READ: begin
        reads = 1'b1;
      end
      `OP_RESET_GO: begin
        legal = armed; // see RL9
      end
      `OP_QUAD_ENTER: begin
        legal = !HOST_QUAD;
      end
      `OP_QUAD_EXIT: begin
        legal = HOST_QUAD;
      end
      `OP_ENTER_OTP, `OP_EXIT_OTP, `OP_SEC_LOCK, `OP_RESET_ARM, `OP_NOP: begin
        legal = 1'b1;
      end
      default: begin
        legal = 1'b0;
      end
    endcase
    new_cmd = HOST_QUAD ? 12'({nb, 1'b0}) + 12'd2 : 12'({nb, 3'b000}) + 12'd8;
    if (CMD_OP == `OP_DISC_TABLE) begin
      new_cmd = 12'(new_cmd + 12'(`DUMMY_CLKS)); // see RL5
      new_tx = {CMD_OP, CMD_ADDR, 8'h00};
    end else begin
      new_tx = {CMD_OP, 16'h0000, CMD_ADDR[7:0], 8'h00}; // see RL3
    end
    next_tx = HOST_QUAD ? {tx[35:0], 4'h0} : {tx[38:0], 1'b0};
    next_rx = HOST_QUAD ? {rx[3:0], din} : {rx[6:0], din[1]}; // see RL11
  end

  // Link data arrives from another domain, so it passes two flops first.
  always_ff @(posedge REF_CLK) begin
    din_meta <= LINK.d_io;
    din <= din_meta;
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      state <= H_WAKE;
      tick <= 3'd0;
      sclk_r <= 1'b0;
      cs_r <= 1'b1;
      tx <= 40'h0;
      hout <= 4'h0;
      hoe_n <= 4'hf;
      clk_cnt <= 12'd0;
      cmd_clks <= 12'd0;
      total_clks <= 12'd0;
      rx <= 8'h00;
      rxc <= 3'd0;
      armed <= 1'b0;
      mode_after <= 1'b0;
      HOST_QUAD <= 1'b0;
      CMD_READY <= 1'b0;
      CMD_ERROR <= 1'b0;
      RD_VALID <= 1'b0;
      RD_DATA <= 8'h00;
    end else begin
      CMD_ERROR <= 1'b0;
      RD_VALID <= 1'b0;
      tick <= (tick == `SCLK_HALF - 3'd1) ? 3'd0 : 3'(tick + 3'd1);
      case (state)
        H_WAKE: begin
          // A few deselected clocks carry the reset into the device's domain.
          if (tick == `SCLK_HALF - 3'd1) begin
            sclk_r <= ~sclk_r;
            if (sclk_r) begin
              clk_cnt <= 12'(clk_cnt + 12'd1);
              if (clk_cnt == `WAKE_PULSES - 12'd1) begin
                state <= H_IDLE;
                CMD_READY <= 1'b1;
              end
            end
          end
        end
        H_IDLE: begin
          tick <= 3'd0;
          if (CMD_VALID) begin
            if (!legal) begin
              CMD_ERROR <= 1'b1;
            end else begin
              CMD_READY <= 1'b0;
              state <= H_RUN;
              armed <= (CMD_OP == `OP_RESET_ARM);
              // The mode flips only after the frame that flips it has gone out whole.
              if (CMD_OP == `OP_QUAD_ENTER || (CMD_OP == `OP_RESET_GO)) begin
                mode_after <= (CMD_OP == `OP_QUAD_ENTER);
              end else if (CMD_OP == `OP_QUAD_EXIT) begin
                mode_after <= 1'b0;
              end else begin
                mode_after <= HOST_QUAD;
              end
              cs_r <= 1'b0;
              clk_cnt <= 12'd0;
              rxc <= 3'd0;
              tx <= new_tx;
              cmd_clks <= new_cmd;
              total_clks <= reads ? 12'(new_cmd + (HOST_QUAD ? {3'b000, CMD_RD_BYTES, 1'b0}
                : {1'b0, CMD_RD_BYTES, 3'b000})) : new_cmd;
              hout <= HOST_QUAD ? new_tx[39:36] : {3'b000, new_tx[39]};
              hoe_n <= HOST_QUAD ? 4'h0 : 4'he;
            end
          end
        end
        H_RUN: begin
          if (tick == `SCLK_HALF - 3'd1) begin
            sclk_r <= ~sclk_r;
            if (!sclk_r && clk_cnt >= cmd_clks) begin
              rx <= next_rx;
              rxc <= (rxc == (HOST_QUAD ? 3'd1 : 3'd7)) ? 3'd0 : 3'(rxc + 3'd1);
              if (rxc == (HOST_QUAD ? 3'd1 : 3'd7)) begin
                RD_VALID <= 1'b1;
                RD_DATA <= next_rx;
              end
            end
            if (sclk_r) begin
              clk_cnt <= 12'(clk_cnt + 12'd1);
              tx <= next_tx;
              hout <= HOST_QUAD ? next_tx[39:36] : {3'b000, next_tx[39]};
              if (12'(clk_cnt + 12'd1) >= cmd_clks) begin
                hoe_n <= 4'hf;
              end
              if (12'(clk_cnt + 12'd1) == total_clks) begin
                cs_r <= 1'b1;
                state <= H_GAP;
                HOST_QUAD <= mode_after;
              end
            end
          end
        end
        H_GAP: begin
          if (tick == `SCLK_HALF - 3'd1) begin
            state <= H_IDLE;
            CMD_READY <= 1'b1;
          end
        end
        default: begin
          state <= H_IDLE;
        end
      endcase
    end
  end

  assign LINK.cs_n = cs_r;
  assign LINK.sclk = sclk_r;
  assign LINK.h_io = hout;
  assign LINK.h_oe_n = hoe_n;
endmodule : flash_id_host

`default_nettype wire

// [flash_id_chk.sv]
`timescale 1ns/1ps
`default_nettype none
`include "flash_id_consts.svh"

module flash_id_chk (
  // System clock and reset
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  // Link signals
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic [3:0] h_io,
  input wire logic [3:0] h_oe_n,
  input wire logic [3:0] d_io,
  input wire logic [3:0] d_oe_n
);
  localparam logic [7:0] MK = `MAKER_ID;
  localparam logic [7:0] SG = `LEGACY_SIG;
  localparam logic [7:0] PL = `PART_LO;
  logic [5:0] cnt;
  logic qf;
  logic [7:0] op;
  logic [7:0] sel;

  // Frame trackers restart on deselect, so every frame is judged on its own.
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) cnt <= 6'h0;
    else if (cnt != 6'h3f) cnt <= cnt + 6'h1;
  end
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) qf <= 1'b0;
    else if (cnt == 6'h0) qf <= (h_oe_n == 4'h0);
  end
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) op <= 8'h0;
    else if (h_oe_n == 4'h0 && cnt < 6'h2) op <= {op[3:0], h_io};
    else if (h_oe_n == 4'he && cnt < 6'h8) op <= {op[6:0], h_io[0]};
  end
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) sel <= 8'h0;
    else if (!qf && cnt >= 6'd24 && cnt < 6'd32) sel <= {sel[6:0], h_io[0]};
  end

  a_release_idle: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    cs_n |-> d_oe_n == 4'hf) else $error("device drives while deselected");
  a_no_fight: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    ((~h_oe_n) & (~d_oe_n)) == 4'h0) else $error("both ends drive one lane");
  a_bit_stable: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    $rose(sclk) && !cs_n && d_oe_n != 4'hf |-> $stable(d_io))
    else $error("read data moved at a sampling edge");
  a_jedec_turn: assert property (@(posedge sclk) disable iff (SYS_RST)
    !qf && op == `OP_JEDEC_ID && cnt == 6'd8 |-> d_oe_n == 4'hd && d_io[1] == MK[7])
    else $error("identity read did not start after the opcode");
  a_sig_turn: assert property (@(posedge sclk) disable iff (SYS_RST)
    !qf && op == `OP_LEGACY_SIG && cnt >= 6'd8 && cnt <= 6'd24
    |-> (d_oe_n == 4'hd) == (cnt == 6'd24)) else $error("signature turn-around wrong");
  a_pair_order: assert property (@(posedge sclk) disable iff (SYS_RST)
    !qf && op == `OP_MAKER_PAIR && cnt == 6'd34 |-> d_io[1] == (sel == 8'h01 ? PL[5] : MK[5]))
    else $error("pair read order wrong");
  a_qid_turn: assert property (@(posedge sclk) disable iff (SYS_RST)
    qf && op == `OP_QUAD_ID && cnt == 6'd2 |-> d_oe_n == 4'h0 && d_io == MK[7:4])
    else $error("quad identity nibble wrong");
  a_table_wait: assert property (@(posedge sclk) disable iff (SYS_RST)
    op == `OP_DISC_TABLE && cnt < (qf ? 6'd16 : 6'd40) |-> d_oe_n == 4'hf)
    else $error("table data before the dummy clocks ended");
  a_table_turn: assert property (@(posedge sclk) disable iff (SYS_RST)
    op == `OP_DISC_TABLE && cnt == (qf ? 6'd16 : 6'd40) |-> d_oe_n == (qf ? 4'h0 : 4'hd))
    else $error("table data late");
  a_sec_turn: assert property (@(posedge sclk) disable iff (SYS_RST)
    !qf && op == `OP_SEC_READ && cnt == 6'd8 |-> d_oe_n == 4'hd && d_io[1] == 1'b0)
    else $error("security read did not start");
endmodule : flash_id_chk

`default_nettype wire

// [flash_id_security_reset_cmds_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "flash_id_consts.svh"

module flash_id_security_reset_cmds_tb;
  logic REF_CLK, SYS_RST, CMD_VALID, CMD_READY, CMD_ERROR, RD_VALID, HOST_QUAD;
  logic OTP_ACTIVE, LOCKED, QUAD_ACTIVE, SOFT_RESET;
  logic [7:0] CMD_OP, CMD_RD_BYTES, RD_DATA;
  logic [23:0] CMD_ADDR;
  int errors, total_checks, nerr, nsoft, seed, i, k;
  logic [7:0] got[$];
  logic [7:0] exp[$];
  bit m_otp, m_lock, m_quad, m_arm;

  flash_link_if flash_link_if_inst();
  flash_id_host flash_id_host_inst(.REF_CLK(REF_CLK), .SYS_RST(SYS_RST),
    .CMD_VALID(CMD_VALID), .CMD_OP(CMD_OP), .CMD_ADDR(CMD_ADDR),
    .CMD_RD_BYTES(CMD_RD_BYTES), .CMD_READY(CMD_READY), .CMD_ERROR(CMD_ERROR),
    .RD_VALID(RD_VALID), .RD_DATA(RD_DATA), .HOST_QUAD(HOST_QUAD),
    .LINK(flash_link_if_inst));
  flash_id_device flash_id_device_inst(.LINK(flash_link_if_inst), .REF_CLK(REF_CLK),
    .SYS_RST(SYS_RST), .OTP_ACTIVE(OTP_ACTIVE), .LOCKED(LOCKED),
    .QUAD_ACTIVE(QUAD_ACTIVE), .SOFT_RESET(SOFT_RESET));
  flash_id_chk flash_id_chk_inst(.REF_CLK(REF_CLK), .SYS_RST(SYS_RST),
    .cs_n(flash_link_if_inst.cs_n), .sclk(flash_link_if_inst.sclk),
    .h_io(flash_link_if_inst.h_io), .h_oe_n(flash_link_if_inst.h_oe_n),
    .d_io(flash_link_if_inst.d_io), .d_oe_n(flash_link_if_inst.d_oe_n));

  initial begin
    REF_CLK = 1'b0;
    forever #25 REF_CLK = ~REF_CLK;
  end

  always @(posedge REF_CLK) begin
    if (RD_VALID === 1'b1) got.push_back(RD_DATA);
    if (CMD_ERROR === 1'b1) nerr++;
    if (SOFT_RESET === 1'b1) nsoft++;
  end

  task automatic check(input logic [7:0] a, input logic [7:0] b, input string what);
    total_checks++;
    if (a !== b) begin
      errors++;
      $display("[ERR] %0t %s: got %h expected %h", $time, what, a, b);
    end
  endtask : check

  task automatic conclude;
    if (errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude

  // Reference model: predicts refusal, read bytes other than table data, and status for one request.
  task automatic run(input logic [7:0] op, input logic [23:0] addr, input logic [7:0] n);
    bit bad;
    bit rd;
    int s0;
    int e0;
    bad = !(op inside {8'h9f, 8'haf, 8'hab, 8'h90, 8'h5a, 8'h2b, 8'hb1, 8'hc1, 8'h2f,
      8'h66, 8'h99, 8'h00, 8'h35, 8'hf5}) || (m_quad && op inside {8'h9f, 8'h90, 8'h35})
      || (!m_quad && op inside {8'haf, 8'hf5}) || (op == 8'h99 && !m_arm);
    rd = op inside {8'h9f, 8'haf, 8'hab, 8'h90, 8'h5a, 8'h2b};
    exp.delete();
    got.delete();
    for (k = 0; k < n && !bad; k++) begin
      case (op)
        8'h9f, 8'haf: exp.push_back(k % 3 == 0 ? `MAKER_ID : k % 3 == 1 ? `PART_HI : `PART_LO);
        8'hab: exp.push_back(`LEGACY_SIG);
        8'h90: exp.push_back(((k % 2 == 1) ^ (addr[7:0] == 8'h01)) ? `PART_LO : `MAKER_ID);
        8'h2b: exp.push_back({6'h0, m_lock, m_otp});
        default: ;
      endcase
    end
    s0 = nsoft;
    e0 = nerr;
    CMD_VALID = 1'b1;
    CMD_OP = op;
    CMD_ADDR = addr;
    CMD_RD_BYTES = n;
    @(negedge REF_CLK);
    CMD_VALID = 1'b0;
    k = 0;
    while (CMD_READY !== 1'b1 && k < 4000) begin
      @(negedge REF_CLK);
      k++;
    end
    if (k == 4000) begin
      errors++;
      $display("[ERR] %0t request never completed", $time);
      conclude();
    end
    // Status flags cross back from the link clock, so give them time to land.
    repeat (12) @(negedge REF_CLK);
    if (!bad) begin
      m_arm = (op == 8'h66);
      case (op)
        8'hb1: m_otp = 1'b1;
        8'hc1: m_otp = 1'b0;
        8'h2f: m_lock = 1'b1;
        8'h35: m_quad = 1'b1;
        8'hf5: m_quad = 1'b0;
        8'h99: {m_otp, m_quad} = 2'b00;
        default: ;
      endcase
    end
    check(8'(nerr - e0), {7'h0, bad}, "refusal");
    check(8'(nsoft - s0), {7'h0, !bad && op == 8'h99}, "soft reset");
    check(8'(got.size()), (bad || !rd) ? 8'h0 : n, "byte count");
    for (k = 0; k < exp.size(); k++) check(got[k], exp[k], "read byte");
    check({5'h0, OTP_ACTIVE, LOCKED, QUAD_ACTIVE}, {5'h0, m_otp, m_lock, m_quad}, "status");
    check({7'h0, HOST_QUAD}, {7'h0, m_quad}, "host mode");
  endtask : run

  initial begin
    seed = 32'h940e;
    {errors, total_checks, nerr, nsoft} = '0;
    {m_otp, m_lock, m_quad, m_arm} = 4'h0;
    SYS_RST = 1'b0;
    CMD_VALID = 1'b0;
    CMD_OP = 8'h0;
    CMD_ADDR = 24'h0;
    CMD_RD_BYTES = 8'h0;
    // A clean rising reset edge reaches the link side even with its clock stopped.
    #1 SYS_RST = 1'b1;
    repeat (3) @(negedge REF_CLK);
    SYS_RST = 1'b0;
    for (i = 0; i < 4000 && CMD_READY !== 1'b1; i++) @(negedge REF_CLK);
    if (i == 4000) begin
      errors++;
      $display("[ERR] %0t host never became ready", $time);
      conclude();
    end
    repeat (20) @(negedge REF_CLK);
    run(8'h9f, 24'h0, 8'd4);
    run(8'hab, 24'h0, 8'd2);
    run(8'h90, 24'h0, 8'd3);
    run(8'h90, 24'h1, 8'd3);
    run(8'haf, 24'h0, 8'd3);
    run(8'h5a, 24'h00000b, 8'd5);
    run(8'h2b, 24'h0, 8'd1);
    run(8'hb1, 24'h0, 8'd0);
    run(8'h2b, 24'h0, 8'd2);
    run(8'h66, 24'h0, 8'd0);
    run(8'h00, 24'h0, 8'd0);
    run(8'h99, 24'h0, 8'd0);
    run(8'h66, 24'h0, 8'd0);
    run(8'h99, 24'h0, 8'd0);
    run(8'h2f, 24'h0, 8'd0);
    run(8'h2b, 24'h0, 8'd1);
    run(8'h35, 24'h0, 8'd0);
    run(8'h9f, 24'h0, 8'd3);
    run(8'haf, 24'h0, 8'd6);
    run(8'hab, 24'h0, 8'd1);
    run(8'h5a, 24'h00000e, 8'd3);
    run(8'hb1, 24'h0, 8'd0);
    run(8'h2b, 24'h0, 8'd1);
    run(8'h66, 24'h0, 8'd0);
    run(8'h99, 24'h0, 8'd0);
    for (i = 0; i < 16; i++) run(8'($random(seed)), 24'($random(seed)), 8'($random(seed)) & 8'h3);
    conclude();
  end
endmodule : flash_id_security_reset_cmds_tb

`default_nettype wire
